// *** sid_pkg.sv ***
// sid_pkg: constants, register map and enumerations for the status lamp driver
// assumes a 125 MHz system clock
package sid_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned SLOW_HALF_MS = 1000;
  localparam int unsigned FAST_HALF_MS = 125;
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned SLOW_PER_FAST = SLOW_HALF_MS / FAST_HALF_MS;
  localparam int TB_W = 25;
  localparam int PH_W = 3;
  localparam logic [TB_W-1:0] TB_LAST = TB_W'(FAST_HALF_CYC - 1);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(SLOW_PER_FAST - 1);
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h3;
  localparam int CTRL_TILT_BIT = 0;
  localparam int CTRL_ALM_BLINK_BIT = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RUN_BIT = 4;
  localparam int STAT_ALM_BIT = 5;
  localparam int STAT_TXA_BIT = 6;
  localparam int STAT_REFL_BIT = 7;
  localparam int EV_W = 5;
  localparam int EV_ALARM = 0;
  localparam int EV_REFL = 1;
  localparam int EV_WEST = 2;
  localparam int EV_EAST = 3;
  localparam int EV_FAULT = 4;
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;
  typedef enum logic [1:0] {
    SID_DARK = 2'b00,
    SID_STEADY = 2'b01,
    SID_SLOW = 2'b10,
    SID_FAST = 2'b11
  } sid_pat_e;
  typedef enum logic [1:0] {
    SID_RUN_OFF = 2'b00,
    SID_RUN_BOOT = 2'b01,
    SID_RUN_OK = 2'b10,
    SID_RUN_FAULT = 2'b11
  } sid_run_e;
endpackage

// *** sid_timebase.sv ***
// sid_timebase: shared blink phases for every lamp
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module sid_timebase
  import sid_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // blink phases
  output logic fast_on,
  output logic slow_on
);
  logic [TB_W-1:0] cnt_ff;
  logic [PH_W-1:0] ph_ff;
  logic fast_ff;
  logic slow_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
      ph_ff <= '0;
      fast_ff <= 1'b1;
      slow_ff <= 1'b1;
    end
    else if (cnt_ff == TB_LAST)
    begin
      cnt_ff <= '0;
      fast_ff <= ~fast_ff;
      if (ph_ff == PH_LAST)
      begin
        ph_ff <= '0;
        slow_ff <= ~slow_ff;
      end
      else
      begin
        ph_ff <= ph_ff + 1'b1;
      end
    end
    else
    begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign fast_on = fast_ff;
  assign slow_on = slow_ff;
endmodule

// *** sid_link_lamp.sv ***
// sid_link_lamp: red/green lamp for one optical link
// assumes blink phases come from the shared timebase
`timescale 1ns/1ps
module sid_link_lamp
  import sid_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // blink phase
  input wire logic slow_on,
  // link status
  input wire logic sfp_present,
  input wire logic cable_ok,
  input wire logic optic_fault,
  input wire logic lock_lost,
  // lamp
  output logic lamp_green,
  output logic lamp_red,
  output logic alarm
);
  logic green_ff;
  logic red_ff;
  logic nxt_green;
  logic nxt_red;

  always_comb
  begin
    nxt_green = 1'b0;
    nxt_red = 1'b0;
    if (!sfp_present || !cable_ok)
    begin
      nxt_red = 1'b0;
    end
    else if (optic_fault)
    begin
      nxt_red = 1'b1;
    end
    else if (lock_lost)
    begin
      nxt_red = slow_on;
    end
    else
    begin
      nxt_green = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      green_ff <= 1'b0;
      red_ff <= 1'b0;
    end
    else
    begin
      green_ff <= nxt_green;
      red_ff <= nxt_red;
    end
  end

  assign lamp_green = green_ff;
  assign lamp_red = red_ff;
  assign alarm = sfp_present & cable_ok & (optic_fault | lock_lost);
endmodule

// *** sid_status_lamps.sv ***
// sid_status_lamps: front-panel status lamp driver with register port and interrupt
// assumes status inputs synchronous to clk; registers on a plain strobe port
// Function
// - the run lamp is steadily lit when power is present but the module reports a fault.
// - the run lamp is dark when there is no supply or the fault stops it being driven.
// - the run lamp blinks slowly in normal running and fast while loading or not started.
// - the alarm lamp is lit steadily or blinks slowly while replacement alarms are active.
// - the alarm lamp is dark when no alarm is active.
// - the transmit lamp is steady when running with transmit enabled or while loading.
// - the transmit lamp blinks slowly when running with transmit disabled.
// - the reflection lamp is dark with no reflection alarm on either antenna port.
// - the reflection lamp is steady with an alarm on antenna port A only.
// - the reflection lamp blinks slowly with an alarm on antenna port B only.
// - the reflection lamp blinks fast with alarms on both antenna ports.
// - each link lamp shows steady green while its link works.
// - a link lamp shows steady red when its transceiver cannot send or receive.
// - a link lamp blinks red slowly when its link has lost lock.
// - a link lamp is dark with no transceiver detected or cable not connected.
// - tilt signalling goes to antenna port A or the tilt port as software selects.
`timescale 1ns/1ps
module sid_status_lamps
  import sid_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [sid_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // unit state monitors
  input wire logic power_ok,
  input wire logic module_fault,
  input wire logic fault_blocks_drive,
  input wire logic sw_loading,
  input wire logic unit_running,
  input wire logic tx_enabled,
  input wire logic replace_alarm,
  input wire logic refl_alarm_a,
  input wire logic refl_alarm_b,
  // west link monitor
  input wire logic west_present,
  input wire logic west_cable_ok,
  input wire logic west_optic_fault,
  input wire logic west_lock_lost,
  // east link monitor
  input wire logic east_present,
  input wire logic east_cable_ok,
  input wire logic east_optic_fault,
  input wire logic east_lock_lost,
  // tilt signalling
  input wire logic tilt_tx,
  output logic tilt_to_port_a,
  output logic tilt_to_tilt_port,
  // lamps
  output logic run_lamp,
  output logic alarm_lamp,
  output logic transmit_activity_lamp,
  output logic reflection_lamp,
  output logic west_link_lamp_green,
  output logic west_link_lamp_red,
  output logic east_link_lamp_green,
  output logic east_link_lamp_red
);
  logic fast_on;
  logic slow_on;
  logic west_alarm;
  logic east_alarm;
  logic [31:0] ctrl_ff;
  logic [EV_W-1:0] irq_stat_ff;
  logic [EV_W-1:0] irq_mask_ff;
  logic [EV_W-1:0] ev_lvl_ff;
  logic [EV_W-1:0] ev_lvl;
  logic [EV_W-1:0] ev_rise;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] stat_word;
  logic run_ff;
  logic alm_ff;
  logic txa_ff;
  logic refl_ff;
  logic tilt_a_ff;
  logic tilt_p_ff;
  logic nxt_run;
  logic nxt_alm;
  logic nxt_txa;
  logic nxt_refl;
  sid_run_e run_state;
  sid_pat_e refl_pat;

  function automatic logic pat_level(input sid_pat_e pat, input logic slow, input logic fast);
    logic lvl;
    lvl = 1'b0;
    unique case (pat)
      SID_DARK: lvl = 1'b0;
      SID_STEADY: lvl = 1'b1;
      SID_SLOW: lvl = slow;
      SID_FAST: lvl = fast;
    endcase
    return lvl;
  endfunction

  sid_timebase u_timebase (
    .clk(clk),
    .rst(rst),
    .fast_on(fast_on),
    .slow_on(slow_on)
  );

  sid_link_lamp u_west (
    .clk(clk),
    .rst(rst),
    .slow_on(slow_on),
    .sfp_present(west_present),
    .cable_ok(west_cable_ok),
    .optic_fault(west_optic_fault),
    .lock_lost(west_lock_lost),
    .lamp_green(west_link_lamp_green),
    .lamp_red(west_link_lamp_red),
    .alarm(west_alarm)
  );

  sid_link_lamp u_east (
    .clk(clk),
    .rst(rst),
    .slow_on(slow_on),
    .sfp_present(east_present),
    .cable_ok(east_cable_ok),
    .optic_fault(east_optic_fault),
    .lock_lost(east_lock_lost),
    .lamp_green(east_link_lamp_green),
    .lamp_red(east_link_lamp_red),
    .alarm(east_alarm)
  );

  // unit run state, fault outranks loading
  always_comb
  begin
    if (!power_ok || (module_fault && fault_blocks_drive))
    begin
      run_state = SID_RUN_OFF;
    end
    else if (module_fault)
    begin
      run_state = SID_RUN_FAULT;
    end
    else if (sw_loading || !unit_running)
    begin
      run_state = SID_RUN_BOOT;
    end
    else
    begin
      run_state = SID_RUN_OK;
    end
  end

  always_comb
  begin
    nxt_run = 1'b0;
    nxt_txa = 1'b0;
    unique case (run_state)
      SID_RUN_OFF:
      begin
        nxt_run = 1'b0;
        nxt_txa = 1'b0;
      end
      SID_RUN_FAULT:
      begin
        nxt_run = 1'b1;
        nxt_txa = 1'b0;
      end
      SID_RUN_BOOT:
      begin
        nxt_run = fast_on;
        nxt_txa = sw_loading;
      end
      SID_RUN_OK:
      begin
        nxt_run = slow_on;
        nxt_txa = tx_enabled ? 1'b1 : slow_on;
      end
    endcase
  end

  always_comb
  begin
    if (!replace_alarm)
    begin
      nxt_alm = 1'b0;
    end
    else
    begin
      nxt_alm = ctrl_ff[CTRL_ALM_BLINK_BIT] ? slow_on : 1'b1;
    end
  end

  always_comb
  begin
    unique case ({refl_alarm_b, refl_alarm_a})
      2'b00: refl_pat = SID_DARK;
      2'b01: refl_pat = SID_STEADY;
      2'b10: refl_pat = SID_SLOW;
      2'b11: refl_pat = SID_FAST;
    endcase
    nxt_refl = pat_level(refl_pat, slow_on, fast_on);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run_ff <= 1'b0;
      alm_ff <= 1'b0;
      txa_ff <= 1'b0;
      refl_ff <= 1'b0;
    end
    else
    begin
      run_ff <= nxt_run;
      alm_ff <= nxt_alm;
      txa_ff <= nxt_txa;
      refl_ff <= nxt_refl;
    end
  end

  // tilt routing
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tilt_a_ff <= 1'b0;
      tilt_p_ff <= 1'b0;
    end
    else
    begin
      tilt_a_ff <= ctrl_ff[CTRL_TILT_BIT] ? 1'b0 : tilt_tx;
      tilt_p_ff <= ctrl_ff[CTRL_TILT_BIT] ? tilt_tx : 1'b0;
    end
  end

  // control and mask registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_ff <= CTRL_RST;
      irq_mask_ff <= MASK_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_CTRL)
      begin
        ctrl_ff <= {30'h0, reg_wdata[CTRL_ALM_BLINK_BIT], reg_wdata[CTRL_TILT_BIT]};
      end
      if (reg_addr == ADDR_IRQ_MASK)
      begin
        irq_mask_ff <= reg_wdata[EV_W-1:0];
      end
    end
  end

  // sticky events on alarm onset; set wins over clear
  always_comb
  begin
    ev_lvl = '0;
    ev_lvl[EV_ALARM] = replace_alarm;
    ev_lvl[EV_REFL] = refl_alarm_a | refl_alarm_b;
    ev_lvl[EV_WEST] = west_alarm;
    ev_lvl[EV_EAST] = east_alarm;
    ev_lvl[EV_FAULT] = module_fault;
  end

  assign ev_rise = ev_lvl & ~ev_lvl_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ev_lvl_ff <= '0;
      irq_stat_ff <= '0;
    end
    else
    begin
      ev_lvl_ff <= ev_lvl;
      if (reg_wr && reg_addr == ADDR_IRQ_STAT)
      begin
        irq_stat_ff <= (irq_stat_ff & ~reg_wdata[EV_W-1:0]) | ev_rise;
      end
      else
      begin
        irq_stat_ff <= irq_stat_ff | ev_rise;
      end
    end
  end

  // status word from lamp and run state fields
  always_comb
  begin
    stat_word = '0;
    stat_word[STAT_STATE_LSB +: $bits(sid_run_e)] = run_state;
    stat_word[STAT_RUN_BIT] = run_ff;
    stat_word[STAT_ALM_BIT] = alm_ff;
    stat_word[STAT_TXA_BIT] = txa_ff;
    stat_word[STAT_REFL_BIT] = refl_ff;
  end

  // read mux, unmapped reads as zero
  always_comb
  begin
    nxt_rdata = '0;
    unique case (reg_addr)
      ADDR_CTRL: nxt_rdata = ctrl_ff;
      ADDR_STAT: nxt_rdata = stat_word;
      ADDR_IRQ_STAT: nxt_rdata = {27'h0, irq_stat_ff};
      ADDR_IRQ_MASK: nxt_rdata = {27'h0, irq_mask_ff};
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_ff <= '0;
    end
    else if (reg_rd)
    begin
      rdata_ff <= nxt_rdata;
    end
    else
    begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = |(irq_stat_ff & irq_mask_ff);
  assign run_lamp = run_ff;
  assign alarm_lamp = alm_ff;
  assign transmit_activity_lamp = txa_ff;
  assign reflection_lamp = refl_ff;
  assign tilt_to_port_a = tilt_a_ff;
  assign tilt_to_tilt_port = tilt_p_ff;
endmodule

// *** sid_status_lamps_checker.sv ***
// checker: lamp and tilt relations at the driver ports
// assumes lamps and tilt outputs registered one cycle after inputs
`timescale 1ns/1ps
module sid_status_lamps_checker
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // monitors
  input wire logic power_ok,
  input wire logic module_fault,
  input wire logic fault_blocks_drive,
  input wire logic unit_running,
  input wire logic tx_enabled,
  input wire logic replace_alarm,
  input wire logic refl_alarm_a,
  input wire logic refl_alarm_b,
  input wire logic west_present,
  input wire logic west_cable_ok,
  input wire logic west_optic_fault,
  input wire logic west_lock_lost,
  input wire logic tilt_tx,
  // outputs
  input wire logic tilt_to_port_a,
  input wire logic tilt_to_tilt_port,
  input wire logic run_lamp,
  input wire logic alarm_lamp,
  input wire logic transmit_activity_lamp,
  input wire logic reflection_lamp,
  input wire logic west_link_lamp_green,
  input wire logic west_link_lamp_red
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_link_up;
    west_present && west_cable_ok;
  endsequence
  a_run_unpowered: assert property ((!power_ok || (module_fault && fault_blocks_drive)) |=> !run_lamp)
    else $error("run lamp lit without drive");
  a_run_fault_lit: assert property (power_ok && module_fault && !fault_blocks_drive |=> run_lamp)
    else $error("run lamp dark on fault");
  a_alarm_quiet: assert property (!replace_alarm |=> !alarm_lamp)
    else $error("alarm lamp lit without alarm");
  a_tx_run_lit: assert property (power_ok && !module_fault && unit_running && tx_enabled
    |=> transmit_activity_lamp)
    else $error("transmit lamp dark while running");
  a_refl_quiet: assert property (!refl_alarm_a && !refl_alarm_b |=> !reflection_lamp)
    else $error("reflection lamp lit without alarm");
  a_refl_a_steady: assert property (refl_alarm_a && !refl_alarm_b |=> reflection_lamp)
    else $error("reflection lamp dark on port a alarm");
  a_link_absent: assert property (!(west_present && west_cable_ok)
    |=> !west_link_lamp_green && !west_link_lamp_red)
    else $error("link lamp lit without transceiver");
  a_link_red: assert property (s_link_up ##0 west_optic_fault
    |=> west_link_lamp_red && !west_link_lamp_green)
    else $error("link lamp not red on optic fault");
  a_link_green: assert property (s_link_up ##0 (!west_optic_fault && !west_lock_lost)
    |=> west_link_lamp_green && !west_link_lamp_red)
    else $error("link lamp not green on good link");
  a_tilt_routed: assert property (tilt_tx |=> tilt_to_port_a != tilt_to_tilt_port)
    else $error("tilt signal not routed to one port");
endmodule
bind sid_status_lamps sid_status_lamps_checker sid_status_lamps_checker_i (.clk, .rst, .power_ok,
  .module_fault, .fault_blocks_drive, .unit_running, .tx_enabled, .replace_alarm, .refl_alarm_a,
  .refl_alarm_b, .west_present, .west_cable_ok, .west_optic_fault, .west_lock_lost, .tilt_tx,
  .tilt_to_port_a, .tilt_to_tilt_port, .run_lamp, .alarm_lamp, .transmit_activity_lamp,
  .reflection_lamp, .west_link_lamp_green, .west_link_lamp_red);

// *** sid_monitor_model.sv ***
// monitor model: unit and link status levels seen by the driver
// assumes the bench sets wanted levels just after a clock edge
`timescale 1ns/1ps
module sid_monitor_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wanted and reported status
  input wire logic [16:0] want,
  output logic [16:0] mon_ff
);
  // monitors report a cycle after the change
  always_ff @(posedge clk)
  begin
    mon_ff <= rst ? 17'h00000 : want;
  end
endmodule

// *** sid_status_lamps_tb.sv ***
// bench: lamp patterns, registers, interrupt and tilt routing
// assumes run stays inside the first blink on phase
`timescale 1ns/1ps
module sid_status_lamps_tb;
  import sid_pkg::*;
  localparam logic [16:0] BASE = 17'h06631;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tilt_tx = 1'b0;
  logic [16:0] want = 17'h00000;
  logic [16:0] mon;
  logic [31:0] reg_rdata;
  logic irq;
  logic tp_a;
  logic tp_t;
  logic [7:0] lamps;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  sid_monitor_model sid_monitor_model_i (.clk(clk), .rst(rst), .want(want), .mon_ff(mon));
  sid_status_lamps sid_status_lamps_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .power_ok(mon[0]),
    .module_fault(mon[1]), .fault_blocks_drive(mon[2]), .sw_loading(mon[3]), .unit_running(mon[4]),
    .tx_enabled(mon[5]), .replace_alarm(mon[6]), .refl_alarm_a(mon[7]), .refl_alarm_b(mon[8]),
    .west_present(mon[9]), .west_cable_ok(mon[10]), .west_optic_fault(mon[11]), .west_lock_lost(mon[12]),
    .east_present(mon[13]), .east_cable_ok(mon[14]), .east_optic_fault(mon[15]), .east_lock_lost(mon[16]),
    .tilt_tx(tilt_tx), .tilt_to_port_a(tp_a), .tilt_to_tilt_port(tp_t), .run_lamp(lamps[7]),
    .alarm_lamp(lamps[6]), .transmit_activity_lamp(lamps[5]), .reflection_lamp(lamps[4]),
    .west_link_lamp_green(lamps[3]), .west_link_lamp_red(lamps[2]), .east_link_lamp_green(lamps[1]),
    .east_link_lamp_red(lamps[0]));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge clk);
    #1;
    chk(reg_rdata, 32'h0);
  endtask
  // blinking lamps read lit: timebase still in its first on phase
  task automatic lamp(input logic [16:0] m, input logic [7:0] exp);
    @(posedge clk);
    want <= m;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(lamps), 32'(exp));
  endtask
  task automatic t_lamps();
    lamp(BASE, 8'hAA);
    lamp(17'h00000, 8'h00);
    lamp(BASE | 17'h00002, 8'h8A);
    lamp(BASE | 17'h00006, 8'h0A);
    lamp(BASE | 17'h00040, 8'hEA);
    lamp(17'h06611, 8'hAA);
    lamp(BASE | 17'h00080, 8'hBA);
    lamp(BASE | 17'h00100, 8'hBA);
    lamp(BASE | 17'h00180, 8'hBA);
    lamp(BASE | 17'h00800, 8'hA6);
    lamp(BASE | 17'h01000, 8'hA6);
    lamp(BASE | 17'h08000, 8'hA9);
    lamp(17'h04631, 8'hA8);
    lamp(17'h06609, 8'hAA);
    lamp(17'h06601, 8'h8A);
  endtask
  task automatic t_regs();
    lamp(BASE, 8'hAA);
    wr(ADDR_IRQ_STAT, 32'h1F);
    rd(ADDR_IRQ_STAT, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    rd(ADDR_CTRL, 32'h2);
    lamp(BASE | 17'h00040, 8'hEA);
    rd(ADDR_STAT, 32'h72);
    rd(ADDR_IRQ_STAT, 32'h1);
    chk(32'(irq), 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1F);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    chk(32'(irq), 32'h0);
    wr(4'h9, 32'hFFFFFFFF);
    rd(4'h9, 32'h0);
  endtask
  task automatic t_tilt();
    for (int s = 0; s < 2; s++)
    begin
      wr(ADDR_CTRL, 32'(s));
      @(posedge clk);
      tilt_tx <= 1'b1;
      @(posedge clk);
      tilt_tx <= 1'b0;
      #1;
      chk(32'({tp_a, tp_t}), (s == 1) ? 32'h1 : 32'h2);
    end
  endtask
  task automatic t_restart();
    @(posedge clk);
    rst <= 1'b1;
    want <= BASE;
    repeat (2) @(posedge clk);
    #1;
    chk(32'({lamps, irq}), 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(lamps), 32'hAA);
    rd(ADDR_IRQ_MASK, 32'h0);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_lamps();
    t_regs();
    t_tilt();
    t_restart();
    print_verdict();
  end
endmodule
